//--- core/ext_irq_cfg.svh
/*
 * Constants for the external interrupt and extended mask/priority block:
 * register indices, reset values, bit positions and source numbers.
 * Assumes it is included by its bare name from the package and the module.
 */
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// Operation
// (RULE1) Enable bit 7 gates port match, bit 6 gates regulator dropout; 1 passes.
// (RULE2) Enable bit 5 gates the LIN controller request; 0 masks it.
// (RULE3) Enable bit 4 gates comparator rising, bit 3 comparator falling requests.
// (RULE4) Enable bit 2 gates every counter array request.
// (RULE5) Enable bit 1 passes conversion done, bit 0 passes window compare.
// (RULE6) Priority bits mirror enable positions; 1 is high; both reset to zero.
// (RULE7) Edge select 1 means edge, 0 level; polarity 0 low, 1 high.
// (RULE8) External pending flags sit at bits 1 and 3 of timer control.
// (RULE9) Edge mode sets pending on the active edge; vectoring clears it.
// (RULE10) Level mode pending simply follows the active level of the input.
// (RULE11) A level source holds its line active until the core recognises it.
// (RULE12) A level source releases before the routine ends, else it requests again.
// (RULE13) Three-bit pin selects: second input bits 6-4, first 2-0; reset 01.
// (RULE14) Config bit 3 is first input polarity, bit 7 the second.
// (RULE15) Pins are sampled without disturbing the crossbar or its peripherals.
// (RULE16) Global enable 0 blocks every source; 1 lets each mask decide.
// (RULE17) High priority wins; within a level the lowest source number wins.
// (RULE18) Selected pins are synchronised before edge or level evaluation.

// Register indices; byte address is four times the index.
`define IDX_TIMER_CTRL   8'h88
`define IDX_BASE_ENABLE  8'hA8
`define IDX_BASE_PRIO    8'hB8
`define IDX_PIN_CONFIG   8'hE4
`define IDX_EXT_ENABLE   8'hE6
`define IDX_EXT_PRIO     8'hF6

// Reset values.
`define RST_PIN_CONFIG   8'h01
`define RST_ZERO8        8'h00
`define RST_ZERO32       32'h0000_0000

// Timer control bit positions.
`define TC_A_EDGE        0
`define TC_A_PEND        1
`define TC_B_EDGE        2
`define TC_B_PEND        3

// Base enable and base priority bit positions.
`define BE_GLOBAL        7
`define BE_EXT_A         0
`define BE_EXT_B         2

// Pin configuration field positions.
`define PC_A_SEL_LSB     0
`define PC_A_POL         3
`define PC_B_SEL_LSB     4
`define PC_B_POL         7
`define PC_SEL_W         3

// Source numbers presented to the core.
`define SRC_EXT_A        4'h0
`define SRC_EXT_B        4'h1
`define SRC_EXT_BASE     2
`define SRC_COUNT        10

`endif

//--- core/ext_irq_pkg.sv
/*
 * Types for the external interrupt and extended mask/priority block.
 * Assumes the constants header is on the include path.
 */
`include "ext_irq_cfg.svh"

package ext_irq_pkg;

    // Setup of one external input.
    typedef struct packed {
        logic                  polarity;
        logic                  edge_mode;
        logic [`PC_SEL_W-1:0]  pin_select;
    } ext_cfg_t;

    // Request presented to the core vectoring logic.
    typedef struct packed {
        logic        valid;
        logic        high;
        logic [3:0]  id;
    } irq_vec_t;

endpackage

//--- core/ext_irq_ctrl.sv
/*
 * External interrupt inputs with polarity, edge/level sensing and pin
 * selection, plus the extended enable and priority banks, an arbiter
 * and an APB register slave.
 * Assumes peripheral flags are on pclk, port pins are asynchronous, and
 * the core acknowledges the source it vectors to with a one-cycle pulse.
 */
`timescale 1ns/1ps

`include "ext_irq_cfg.svh"

module ext_irq_ctrl
    import ext_irq_pkg::*;
#(
    parameter int PIN_COUNT = 8,
    parameter int ADDR_W    = 12
) (
    // Clock and reset.
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave.
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Port pins, sampled only.
    input  wire logic [PIN_COUNT-1:0] port_pins,
    // Peripheral request flags in extended enable bit order.
    input  wire logic [7:0]         source_flags,
    // Core vectoring handshake.
    input  wire logic               vector_ack,
    input  wire logic [3:0]         vector_id,
    output irq_vec_t                irq_out,
    // Pending flags for observation.
    output logic                    ext_a_pending,
    output logic                    ext_b_pending
);

    // =====================================================================
    // Registers
    // =====================================================================

    logic [7:0]  pin_config;
    logic [7:0]  extended_irq_enable;
    logic [7:0]  extended_irq_priority;
    logic [7:0]  base_enable;
    logic [7:0]  base_prio;
    logic [1:0]  edge_sel;
    logic [1:0]  edge_pend;

    logic [7:0]  reg_index;
    logic        setup_phase;
    logic        wr_take;
    logic        idx_hit;

    // The transfer is answered in its first access cycle.
    assign pready      = 1'b1;
    assign reg_index   = paddr[9:2];
    assign setup_phase = psel & ~penable;
    assign wr_take     = psel & penable & pwrite & pstrb[0] & idx_hit;

    // Decode of mapped indices.
    always_comb begin
        case (reg_index)
            `IDX_TIMER_CTRL,
            `IDX_BASE_ENABLE,
            `IDX_BASE_PRIO,
            `IDX_PIN_CONFIG,
            `IDX_EXT_ENABLE,
            `IDX_EXT_PRIO: idx_hit = (paddr[ADDR_W-1:10] == '0) & (paddr[1:0] == 2'b00);
            default:       idx_hit = 1'b0;
        endcase
    end

    // Pin configuration register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_config <= `RST_PIN_CONFIG; // RULE13
        end else if (wr_take && reg_index == `IDX_PIN_CONFIG) begin
            pin_config <= pwdata[7:0]; // RULE13 RULE14
        end
    end

    // Extended enable register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extended_irq_enable <= `RST_ZERO8; // RULE6
        end else if (wr_take && reg_index == `IDX_EXT_ENABLE) begin
            extended_irq_enable <= pwdata[7:0];
        end
    end

    // Extended priority register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extended_irq_priority <= `RST_ZERO8; // RULE6
        end else if (wr_take && reg_index == `IDX_EXT_PRIO) begin
            extended_irq_priority <= pwdata[7:0]; // RULE6
        end
    end

    // Global and external-input enables.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_enable <= `RST_ZERO8;
        end else if (wr_take && reg_index == `IDX_BASE_ENABLE) begin
            base_enable <= pwdata[7:0];
        end
    end

    // External-input priorities.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_prio <= `RST_ZERO8;
        end else if (wr_take && reg_index == `IDX_BASE_PRIO) begin
            base_prio <= pwdata[7:0];
        end
    end

    // Edge or level selection bits in timer control.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel <= 2'b00;
        end else if (wr_take && reg_index == `IDX_TIMER_CTRL) begin
            edge_sel[0] <= pwdata[`TC_A_EDGE]; // RULE7
            edge_sel[1] <= pwdata[`TC_B_EDGE]; // RULE7
        end
    end

    // =====================================================================
    // Pin synchronisers
    // =====================================================================

    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic [PIN_COUNT-1:0] sync3;
    logic [PIN_COUNT-1:0] pin_clean;

    // Each pin passes three flops; a change counts when the last two agree.
    // Only an input path exists, so crossbar users of the pin are untouched.
    genvar gp;
    generate
        for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[gp]     <= 1'b0;
                    sync2[gp]     <= 1'b0;
                    sync3[gp]     <= 1'b0;
                    pin_clean[gp] <= 1'b0;
                end else begin
                    sync1[gp] <= port_pins[gp]; // RULE15 RULE18
                    sync2[gp] <= sync1[gp];
                    sync3[gp] <= sync2[gp];
                    if (sync2[gp] == sync3[gp]) begin
                        pin_clean[gp] <= sync3[gp]; // RULE18
                    end
                end
            end
        end
    endgenerate

    // =====================================================================
    // External inputs
    // =====================================================================

    ext_cfg_t [1:0] ext_cfg;
    logic     [1:0] ext_active;
    logic     [1:0] ext_prev;
    logic     [1:0] ext_rise;
    logic     [1:0] ext_flag;
    logic     [1:0] ack_clear;
    logic     [1:0] sw_pend;

    // Per-input setup gathered from the registers.
    assign ext_cfg[0] = '{polarity:   pin_config[`PC_A_POL],
                          edge_mode:  edge_sel[0],
                          pin_select: pin_config[`PC_A_SEL_LSB +: `PC_SEL_W]};
    assign ext_cfg[1] = '{polarity:   pin_config[`PC_B_POL],
                          edge_mode:  edge_sel[1],
                          pin_select: pin_config[`PC_B_SEL_LSB +: `PC_SEL_W]};

    assign ack_clear[0] = vector_ack & (vector_id == `SRC_EXT_A);
    assign ack_clear[1] = vector_ack & (vector_id == `SRC_EXT_B);
    assign sw_pend[0]   = pwdata[`TC_A_PEND];
    assign sw_pend[1]   = pwdata[`TC_B_PEND];

    genvar ge;
    generate
        for (ge = 0; ge < 2; ge++) begin : g_ext
            // Active when the selected pin matches the polarity bit.
            assign ext_active[ge] =
                ~(pin_clean[ext_cfg[ge].pin_select] ^ ext_cfg[ge].polarity); // RULE7 RULE13 RULE14
            assign ext_rise[ge] = ext_active[ge] & ~ext_prev[ge];

            // Previous active level for edge detection.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ext_prev[ge] <= 1'b0;
                end else begin
                    ext_prev[ge] <= ext_active[ge];
                end
            end

            // Edge pending: a new edge wins over any clear in the same cycle.
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    edge_pend[ge] <= 1'b0;
                end else if (ext_cfg[ge].edge_mode && ext_rise[ge]) begin
                    edge_pend[ge] <= 1'b1; // RULE9
                end else if (ack_clear[ge]) begin
                    edge_pend[ge] <= 1'b0; // RULE9
                end else if (wr_take && reg_index == `IDX_TIMER_CTRL) begin
                    edge_pend[ge] <= sw_pend[ge];
                end
            end

            // Level mode follows the input; edge mode shows the sticky bit.
            assign ext_flag[ge] = ext_cfg[ge].edge_mode ? edge_pend[ge]
                                                        : ext_active[ge]; // RULE10 RULE12
        end
    endgenerate

    // Pending flags shown as registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_a_pending <= 1'b0;
            ext_b_pending <= 1'b0;
        end else begin
            ext_a_pending <= ext_flag[0];
            ext_b_pending <= ext_flag[1];
        end
    end

    // =====================================================================
    // Masking and arbitration
    // =====================================================================

    logic [`SRC_COUNT-1:0] req_vec;
    logic [`SRC_COUNT-1:0] prio_vec;
    logic [`SRC_COUNT-1:0] en_vec;
    irq_vec_t              next_irq;
    logic                  found_high;
    logic                  found_low;

    // Extended sources keep their enable bit order after the two inputs.
    assign en_vec = {extended_irq_enable,                   // RULE1 RULE2 RULE3 RULE4 RULE5
                     base_enable[`BE_EXT_B], base_enable[`BE_EXT_A]};
    assign prio_vec = {extended_irq_priority,               // RULE6
                       base_prio[`BE_EXT_B], base_prio[`BE_EXT_A]};
    assign req_vec = {source_flags, ext_flag} & en_vec
                   & {`SRC_COUNT{base_enable[`BE_GLOBAL]}};  // RULE16

    // High level first, then low; lowest number within a level.
    always_comb begin
        next_irq   = '0;
        found_high = 1'b0;
        found_low  = 1'b0;
        for (int i = 0; i < `SRC_COUNT; i++) begin
            if (req_vec[i] && prio_vec[i] && !found_high) begin
                found_high = 1'b1;
                next_irq.id = 4'(i); // RULE17
            end
        end
        for (int i = 0; i < `SRC_COUNT; i++) begin
            if (req_vec[i] && !prio_vec[i] && !found_high && !found_low) begin
                found_low = 1'b1;
                next_irq.id = 4'(i); // RULE17
            end
        end
        next_irq.valid = found_high | found_low;
        next_irq.high  = found_high;
    end

    // Registered request to the core; a level source must hold meanwhile.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_out <= '0;
        end else begin
            irq_out <= next_irq; // RULE11
        end
    end

    // =====================================================================
    // Read path
    // =====================================================================

    logic [7:0] read_byte;
    logic [7:0] timer_view;

    // Timer control view: edge selects and pending flags in place.
    always_comb begin
        timer_view = `RST_ZERO8;
        timer_view[`TC_A_EDGE] = edge_sel[0];
        timer_view[`TC_A_PEND] = ext_flag[0]; // RULE8
        timer_view[`TC_B_EDGE] = edge_sel[1];
        timer_view[`TC_B_PEND] = ext_flag[1]; // RULE8
    end

    // Register select for reads.
    always_comb begin
        case (reg_index)
            `IDX_TIMER_CTRL:  read_byte = timer_view;
            `IDX_BASE_ENABLE: read_byte = base_enable;
            `IDX_BASE_PRIO:   read_byte = base_prio;
            `IDX_PIN_CONFIG:  read_byte = pin_config;
            `IDX_EXT_ENABLE:  read_byte = extended_irq_enable;
            `IDX_EXT_PRIO:    read_byte = extended_irq_priority;
            default:          read_byte = `RST_ZERO8;
        endcase
    end

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `RST_ZERO32;
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            prdata  <= idx_hit ? {24'h00_0000, read_byte} : `RST_ZERO32;
            pslverr <= ~idx_hit;
        end
    end

endmodule

//--- testbench/ext_irq_ctrl_assertions.sv
/* Checker for ext_irq_ctrl: shadows accepted register writes and ties the
   core request and the read data to them.
   Sees only the top module ports and is bound to every instance below. */
`timescale 1ns/1ps
`include "ext_irq_cfg.svh"
module ext_irq_ctrl_checker
    import ext_irq_pkg::*;
#(
    parameter int PIN_COUNT = 8,
    parameter int ADDR_W    = 12
) (
    // Clock and reset.
    input wire logic                 pclk,
    input wire logic                 presetn,
    // Register bus.
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Pins, flags and core side.
    input wire logic [PIN_COUNT-1:0] port_pins,
    input wire logic [7:0]           source_flags,
    input wire logic                 vector_ack,
    input wire logic [3:0]           vector_id,
    input irq_vec_t                  irq_out,
    input wire logic                 ext_a_pending,
    input wire logic                 ext_b_pending
);
    // ==========================================
    // Shadow state
    logic [7:0] cf, en, pr, be, bp, tc, p_en, p_pr, p_be, p_bp, p_fl, sd, sel, idx;
    logic [9:0] req, hi;
    logic       hit, mapped;

    // Decodes the word index and the shadow that a read would return.
    always_comb begin
        idx = paddr[9:2];
        mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && idx inside {`IDX_TIMER_CTRL,
                 `IDX_BASE_ENABLE, `IDX_BASE_PRIO, `IDX_PIN_CONFIG, `IDX_EXT_ENABLE, `IDX_EXT_PRIO};
        hit = mapped && idx inside {`IDX_PIN_CONFIG, `IDX_EXT_ENABLE, `IDX_EXT_PRIO};
        sel = idx == `IDX_PIN_CONFIG ? cf : (idx == `IDX_EXT_ENABLE ? en : pr);
    end

    // Follows every accepted write into the shadows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en, pr, be, bp, tc} <= '0;
            cf <= `RST_PIN_CONFIG;
        end else if (psel && penable && pready && pwrite && pstrb[0] && mapped) begin
            case (idx)
                `IDX_PIN_CONFIG:  cf <= pwdata[7:0];
                `IDX_EXT_ENABLE:  en <= pwdata[7:0];
                `IDX_EXT_PRIO:    pr <= pwdata[7:0];
                `IDX_BASE_ENABLE: be <= pwdata[7:0];
                `IDX_BASE_PRIO:   bp <= pwdata[7:0];
                default:          tc <= pwdata[7:0];
            endcase
        end
    end

    // Keeps the values that the registered request was computed from.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {p_en, p_pr, p_be, p_bp, p_fl, sd} <= '0;
        end else begin
            {p_en, p_pr, p_be, p_bp, p_fl, sd} <= {en, pr, be, bp, source_flags, sel};
        end
    end

    // Enabled requests in source order, and those among them at high priority.
    assign req = {p_fl & p_en, ext_b_pending & p_be[2], ext_a_pending & p_be[0]} & {10{p_be[7]}};
    assign hi = req & {p_pr, p_bp[2], p_bp[0]};

    // Lowest set source number of a request vector.
    function automatic logic [3:0] first(input logic [9:0] v);
        first = 4'hF;
        for (int i = 9; i >= 0; i--) if (v[i]) first = 4'(i);
    endfunction

    // ==========================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;  psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    sequence s_ack_a;  vector_ack && vector_id == `SRC_EXT_A && tc[`TC_A_EDGE] && ext_a_pending; endsequence

    property p_global;  !p_be[`BE_GLOBAL] |-> !irq_out.valid; endproperty
    property p_mask;    irq_out.valid |-> req[irq_out.id]; endproperty
    property p_present; req != 10'h000 |-> irq_out.valid; endproperty
    property p_level;   irq_out.valid |-> irq_out.high == (hi != 10'h000); endproperty
    property p_order;   irq_out.valid |-> irq_out.id == first(hi != 10'h000 ? hi : req); endproperty
    property p_ack;     s_ack_a |-> ##2 !ext_a_pending; endproperty
    property p_rd;      s_setup ##1 (s_access and !pwrite && hit) |-> prdata == {24'h0, sd}; endproperty
    property p_err;     s_access |-> pslverr == !mapped; endproperty

    a_global: assert property (p_global) else $error("request while globally off");
    a_mask: assert property (p_mask) else $error("masked source presented");
    a_present: assert property (p_present) else $error("enabled request not presented");
    a_level: assert property (p_level) else $error("wrong priority level");
    a_order: assert property (p_order) else $error("wrong source chosen");
    a_ack: assert property (p_ack) else $error("edge pending kept after vectoring");
    a_rd: assert property (p_rd) else $error("read data differs from written value");
    a_err: assert property (p_err) else $error("slave error wrong for address");
endmodule

bind ext_irq_ctrl ext_irq_ctrl_checker #(.PIN_COUNT(PIN_COUNT), .ADDR_W(ADDR_W)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins), .source_flags(source_flags),
    .vector_ack(vector_ack), .vector_id(vector_id), .irq_out(irq_out),
    .ext_a_pending(ext_a_pending), .ext_b_pending(ext_b_pending));

//--- testbench/core_vector_model.sv
/* Model of the core vectoring logic: takes a presented request after a set
   wait and acknowledges it with a one-cycle pulse carrying its source.
   Assumes irq_out is registered on pclk. */
`timescale 1ns/1ps
module core_vector_model
    import ext_irq_pkg::*;
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Request and bench controls.
    input  irq_vec_t        irq_out,
    input  wire logic       ack_on,
    input  wire logic [3:0] ack_wait,
    // Acknowledge to the block.
    output logic            vector_ack,
    output logic [3:0]      vector_id
);
    // ==========================================
    // Vectoring
    logic [3:0] wait_cnt;

    // Counts while a request stands; after a pulse the stale request is let
    // drain, and the idle id inverts again on every idle cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            vector_ack <= 1'b0;
            vector_id <= 4'h0;
        end else if (vector_ack || !irq_out.valid || !ack_on) begin
            wait_cnt <= 4'h0;
            vector_ack <= 1'b0;
            vector_id <= ~vector_id;
        end else if (wait_cnt == ack_wait) begin
            vector_ack <= 1'b1;
            vector_id <= irq_out.id;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule

//--- testbench/test_ext_irq_and_extended_mask_priority.sv
/* Self-checking bench for ext_irq_ctrl with the core model on its far side.
   Assumes a one-cycle bus answer and the source numbering of the block. */
`timescale 1ns/1ps
`include "ext_irq_cfg.svh"
module test_ext_irq_and_extended_mask_priority;
    import ext_irq_pkg::*;
    // ==========================================
    // Signals
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ack_on = 0, probe = 0;
    logic        pready, pslverr, vector_ack, ext_a_pending, ext_b_pending;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, exp_q[$];
    logic [3:0]  pstrb = 4'hF, vector_id, ack_wait = 4'h3;
    logic [7:0]  port_pins = 8'h80, source_flags = '0, en, pr, fl;
    irq_vec_t    irq_out;
    integer      seed = 32'h33AFEAAC;
    int          n_mismatch = 0, checked = 0, cycles = 0;

    always #20 pclk = ~pclk;

    ext_irq_ctrl ext_irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_pins(port_pins), .source_flags(source_flags),
        .vector_ack(vector_ack), .vector_id(vector_id), .irq_out(irq_out),
        .ext_a_pending(ext_a_pending), .ext_b_pending(ext_b_pending));
    core_vector_model core_vector_model_i (.pclk(pclk), .presetn(presetn), .irq_out(irq_out),
        .ack_on(ack_on), .ack_wait(ack_wait), .vector_ack(vector_ack), .vector_id(vector_id));

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, data};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] want);
        exp_q.push_back(want);
        apb(1'b0, idx, 8'h00);
    endtask

    task automatic expect_irq(input logic [5:0] want);
        exp_q.push_back({26'h0, want});
        @(posedge pclk);
        probe <= 1'b1;
        @(posedge pclk);
        probe <= 1'b0;
    endtask

    // Expected request: high level first, then lowest source number.
    function automatic logic [5:0] arb(input logic [7:0] e, input logic [7:0] p, input logic [7:0] f);
        arb = 6'h00;
        for (int i = 7; i >= 0; i--) if (e[i] && f[i] && !p[i]) arb = {2'b10, 4'(i + 2)};
        for (int i = 7; i >= 0; i--) if (e[i] && f[i] && p[i]) arb = {2'b11, 4'(i + 2)};
    endfunction

    // Compares each read or probed request with the oldest expectation.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) check({pslverr, prdata[30:0]}, exp_q.pop_front());
        if (probe) check({26'h0, irq_out.valid, irq_out.valid ? irq_out[4:0] : 5'h0}, exp_q.pop_front());
    end

    // Cuts a hang short.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ==========================================
    // Scenarios
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_PIN_CONFIG, 32'h01);
        rd(`IDX_EXT_ENABLE, 32'h00);
        rd(`IDX_EXT_PRIO, 32'h00);
        rd(8'h10, 32'h80000000);
        apb(1'b1, `IDX_BASE_ENABLE, 8'h80);
        // Random masks, priorities and flags against the expected winner.
        for (int k = 0; k < 26; k++) begin
            en = $random(seed);
            pr = $random(seed);
            fl = $random(seed);
            apb(1'b1, `IDX_EXT_ENABLE, en);
            apb(1'b1, `IDX_EXT_PRIO, pr);
            rd(`IDX_EXT_ENABLE, {24'h0, en});
            rd(`IDX_EXT_PRIO, {24'h0, pr});
            source_flags <= fl;
            repeat (2) @(posedge pclk);
            expect_irq(arb(en, pr, fl));
        end
        apb(1'b1, `IDX_BASE_ENABLE, 8'h00);
        source_flags <= 8'hFF;
        repeat (2) @(posedge pclk);
        expect_irq(6'h00);
        source_flags <= 8'h00;
        // Input A edge on pin 5 active high, input B level on pin 7 active low.
        apb(1'b1, `IDX_PIN_CONFIG, 8'h7D);
        apb(1'b1, `IDX_TIMER_CTRL, 8'h01);
        apb(1'b1, `IDX_BASE_ENABLE, 8'h85);
        rd(`IDX_PIN_CONFIG, 32'h7D);
        rd(`IDX_TIMER_CTRL, 32'h01);
        port_pins <= 8'hA0;
        repeat (8) @(posedge pclk);
        rd(`IDX_TIMER_CTRL, 32'h03);
        expect_irq(6'h20);
        ack_on <= 1'b1;
        repeat (10) @(posedge pclk);
        rd(`IDX_TIMER_CTRL, 32'h01);
        port_pins <= 8'h20;
        repeat (8) @(posedge pclk);
        rd(`IDX_TIMER_CTRL, 32'h09);
        expect_irq(6'h21);
        port_pins <= 8'hA0;
        repeat (8) @(posedge pclk);
        rd(`IDX_TIMER_CTRL, 32'h01);
        expect_irq(6'h00);
        // Every pin code on both inputs, level mode, active high.
        apb(1'b1, `IDX_TIMER_CTRL, 8'h00);
        for (int p = 0; p < 8; p++) begin
            apb(1'b1, `IDX_PIN_CONFIG, {1'b1, 3'(p), 1'b1, 3'(p)});
            port_pins <= 8'h01 << p;
            repeat (8) @(posedge pclk);
            rd(`IDX_TIMER_CTRL, 32'h0A);
            port_pins <= ~(8'h01 << p);
            repeat (8) @(posedge pclk);
            rd(`IDX_TIMER_CTRL, 32'h00);
        end
        repeat (4) @(posedge pclk);
        complete_run();
    end
endmodule
